// ==== core/dmsp_map.vh ====
`ifndef DMSP_MAP_VH
`define DMSP_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DMSP_CTRL_OFS 12'h000
`define DMSP_TXBUF_OFS 12'h004
`define DMSP_RXBUF_OFS 12'h008
`define DMSP_STAT_OFS 12'h00C
`define DMSP_IRQST_OFS 12'h010
`define DMSP_IRQMSK_OFS 12'h014
`define DMSP_BAUD_OFS 12'h018
// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define DMSP_CTRL_PORT_EN 0
`define DMSP_CTRL_TX_EN 1
`define DMSP_CTRL_RX_EN 2
`define DMSP_CTRL_ASYNC 3
`define DMSP_CTRL_EXT_CLK 4
`define DMSP_CTRL_RDY_EN 5
`define DMSP_CTRL_TXI_SEL 6
// ----------------------------------------------------------------
// status and interrupt bit positions
// ----------------------------------------------------------------
`define DMSP_ST_TBE 0
`define DMSP_ST_TSC 1
`define DMSP_ST_RBF 2
`define DMSP_IRQ_TX 0
`define DMSP_IRQ_RX 1
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DMSP_CTRL_RST 7'h00
`define DMSP_BAUD_RST 8'h03
`define DMSP_MASK_RST 2'h0
`endif

// ==== core/dmsp_sync.v ====
`timescale 1ns/1ps
// two flop synchroniser for pin levels
module dmsp_sync
(
  input wire pclk,
  input wire presetn,
  input wire d,
  output wire q
);
reg m_q;
reg s_q;
// ----------------------------------------------------------------
// capture
// ----------------------------------------------------------------
// first flop feeds only the second
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    m_q <= 1'b1;
    s_q <= 1'b1;
  end
  else
  begin
    m_q <= d;
    s_q <= m_q;
  end
end
assign q = s_q;
endmodule // dmsp_sync

// ==== core/dmsp_tick.v ====
`timescale 1ns/1ps
// internal shift clock: toggles every baud+1 cycles
module dmsp_tick
(
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [7:0] baud,
  output reg sclk_q,
  output wire fall,
  output wire rise
);
reg [7:0] cnt_q;
wire hit;
assign hit = run && (cnt_q == baud);
assign fall = hit && sclk_q;
assign rise = hit && !sclk_q;
// ----------------------------------------------------------------
// divider
// ----------------------------------------------------------------
// idles high so a first fall opens each bit cell
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    cnt_q <= 8'h00;
    sclk_q <= 1'b1;
  end
  else if (!run)
  begin
    cnt_q <= 8'h00;
    sclk_q <= 1'b1;
  end
  else if (hit)
  begin
    cnt_q <= 8'h00;
    sclk_q <= !sclk_q;
  end
  else
  begin
    cnt_q <= cnt_q + 8'h01;
  end
end
endmodule // dmsp_tick

// ==== core/dmsp_core.v ====
`timescale 1ns/1ps
`include "dmsp_map.vh"
module dmsp_core
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire txd_in,
  output wire txd_out,
  output wire txd_oe,
  input wire rxd_in,
  input wire shift_clock_pin_in,
  output wire shift_clock_pin_out,
  output wire shift_clock_pin_oe,
  output wire receiver_ready_pin_n,
  output wire receiver_ready_pin_oe,
  output reg [3:0] gpio_in_q
);
// ----------------------------------------------------------------
// declarations
// ----------------------------------------------------------------
reg [6:0] ctrl_q;
reg [7:0] baud_q;
reg [7:0] txbuf_q;
reg [7:0] txsh_q;
reg [7:0] rxsh_q;
reg [7:0] rxbuf_q;
reg [3:0] txcnt_q;
reg [3:0] rxcnt_q;
reg tbe_q;
reg tsc_q;
reg rbf_q;
reg txbusy_q;
reg txout_q;
reg rxbusy_q;
reg [1:0] irqst_q;
reg [1:0] mask_q;
reg sclk_d1_q;
wire sclk_s;
wire rxd_s;
wire txd_s;
wire port_en;
wire tx_en;
wire rx_en;
wire async_m;
wire ext_clk;
wire wr;
wire rd;
wire tick_run;
wire int_sclk;
wire int_fall;
wire int_rise;
wire ext_fall;
wire ext_rise;
wire sh_fall;
wire sh_rise;
wire txbuf_wr;
wire tx_load;
wire rx_run;
wire tx_irq_ev;
wire rx_irq_ev;
wire [1:0] w1c;
// ----------------------------------------------------------------
// address decode helper
// ----------------------------------------------------------------
function is_reg;
  input [11:0] a;
  input [11:0] ofs;
  begin
    is_reg = (a == ofs);
  end
endfunction
assign wr = psel && penable && pwrite;
assign rd = psel && !pwrite;
assign pready = 1'b1;
assign pslverr = 1'b0;
assign port_en = ctrl_q[`DMSP_CTRL_PORT_EN];
assign tx_en = ctrl_q[`DMSP_CTRL_TX_EN];
assign rx_en = ctrl_q[`DMSP_CTRL_RX_EN];
assign async_m = ctrl_q[`DMSP_CTRL_ASYNC];
assign ext_clk = ctrl_q[`DMSP_CTRL_EXT_CLK] && !async_m;
assign txbuf_wr = wr && is_reg(paddr, `DMSP_TXBUF_OFS);
// ----------------------------------------------------------------
// pin input synchronisers
// ----------------------------------------------------------------
dmsp_sync u_sync_sclk
(
  .pclk(pclk),
  .presetn(presetn),
  .d(shift_clock_pin_in),
  .q(sclk_s)
);
dmsp_sync u_sync_rxd
(
  .pclk(pclk),
  .presetn(presetn),
  .d(rxd_in),
  .q(rxd_s)
);
// general port level of the data pin is a pin too
dmsp_sync u_sync_txd
(
  .pclk(pclk),
  .presetn(presetn),
  .d(txd_in),
  .q(txd_s)
);
// general port inputs when the port is disabled
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    gpio_in_q <= 4'h0;
    sclk_d1_q <= 1'b1;
  end
  else
  begin
    gpio_in_q <= {1'b0, sclk_s, rxd_s, txd_s};
    sclk_d1_q <= sclk_s;
  end
end
assign ext_fall = sclk_d1_q && !sclk_s;
assign ext_rise = !sclk_d1_q && sclk_s;
// ----------------------------------------------------------------
// shift clock
// ----------------------------------------------------------------
// sync mode: clock runs for either direction, not just tx
// a pending buffer must run the clock, or no fall ever loads it
assign tick_run = async_m ? (txbusy_q || rxbusy_q || !tbe_q)
  : (txbusy_q || !tbe_q || (rx_en && port_en));
dmsp_tick u_tick
(
  .pclk(pclk),
  .presetn(presetn),
  .run(tick_run),
  .baud(baud_q),
  .sclk_q(int_sclk),
  .fall(int_fall),
  .rise(int_rise)
);
// one shared clock for both directions in sync mode
assign sh_fall = ext_clk ? ext_fall : int_fall;
assign sh_rise = ext_clk ? ext_rise : int_rise;
// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
// load only on a shift-clock fall, so done drops 0..1 clocks late, 0.5 from an idle clock
assign tx_load = !txbusy_q && !tbe_q && sh_fall;
// port enable gates pins only, never the shifter
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    txbuf_q <= 8'h00;
    txsh_q <= 8'h00;
    txcnt_q <= 4'h0;
    txbusy_q <= 1'b0;
    txout_q <= 1'b1;
    tbe_q <= 1'b1;
    tsc_q <= 1'b1;
  end
  else
  begin
    if (wr && is_reg(paddr, `DMSP_CTRL_OFS) &&
        pwdata[`DMSP_CTRL_TX_EN] && !tx_en)
    begin
      tbe_q <= 1'b1;
      tsc_q <= 1'b1;
    end
    else if (txbuf_wr && (tx_en || txbusy_q))
    begin
      txbuf_q <= pwdata[7:0];
      tbe_q <= 1'b0;
    end
    else if (tx_load)
    begin
      txsh_q <= txbuf_q;
      txbusy_q <= 1'b1;
      tsc_q <= 1'b0;
      tbe_q <= 1'b1;
      txcnt_q <= 4'h0;
      txout_q <= async_m ? 1'b0 : txbuf_q[0];
    end
    // sync: eighth rise ends the frame, clock left high, no extra edge
    else if (txbusy_q && !async_m && sh_rise && (txcnt_q == 4'h7))
    begin
      txbusy_q <= 1'b0;
      tsc_q <= 1'b1;
    end
    else if (txbusy_q && sh_fall)
    begin
      if (txcnt_q == (async_m ? 4'h9 : 4'h7))
      begin
        txbusy_q <= 1'b0;
        tsc_q <= 1'b1;
        txout_q <= 1'b1;
      end
      else
      begin
        txcnt_q <= txcnt_q + 4'h1;
        txsh_q <= async_m ? txsh_q : {1'b1, txsh_q[7:1]};
        txout_q <= async_m ? (txcnt_q < 4'h8 ? txsh_q[txcnt_q[2:0]]
                                             : 1'b1)
                           : txsh_q[1];
      end
    end
    // async: clearing transmit enable alone stops the transmitter
    if (async_m && !tx_en && txbusy_q)
    begin
      txbusy_q <= 1'b0;
      tsc_q <= 1'b1;
      txout_q <= 1'b1;
    end
  end
end
// pins revert to general ports while disabled; data hidden
assign txd_out = txout_q;
assign txd_oe = port_en && tx_en;
assign shift_clock_pin_out = int_sclk;
assign shift_clock_pin_oe = port_en && !async_m && !ext_clk;
// ready driven only with receive, ready and transmit all on
assign receiver_ready_pin_oe = port_en && !async_m &&
  ctrl_q[`DMSP_CTRL_RDY_EN] && rx_en && tx_en;
assign receiver_ready_pin_n = !(rx_en && !rbf_q);
// ----------------------------------------------------------------
// receiver
// ----------------------------------------------------------------
// either enable off stops reception in both modes
assign rx_run = rx_en && port_en;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rxsh_q <= 8'h00;
    rxbuf_q <= 8'h00;
    rxcnt_q <= 4'h0;
    rxbusy_q <= 1'b0;
    rbf_q <= 1'b0;
  end
  else
  begin
    if (rd && penable && is_reg(paddr, `DMSP_RXBUF_OFS))
      rbf_q <= 1'b0;
    if (!rx_run)
    begin
      rxbusy_q <= 1'b0;
      rxcnt_q <= 4'h0;
    end
    else if (async_m && !rxbusy_q && !rxd_s)
    begin
      rxbusy_q <= 1'b1;
      rxcnt_q <= 4'h0;
    end
    else if ((rxbusy_q || !async_m) && sh_rise)
    begin
      rxcnt_q <= rxcnt_q + 4'h1;
      if (!async_m || (rxcnt_q != 4'h0 && rxcnt_q < 4'h9))
        rxsh_q <= {rxd_s, rxsh_q[7:1]};
      if (rxcnt_q == (async_m ? 4'h9 : 4'h7))
      begin
        rxbuf_q <= async_m ? rxsh_q : {rxd_s, rxsh_q[7:1]};
        rbf_q <= 1'b1; // receive event wins over the read clear
        rxbusy_q <= 1'b0;
        rxcnt_q <= 4'h0;
      end
    end
  end
end
// ----------------------------------------------------------------
// control and divider registers
// ----------------------------------------------------------------
// no lockout: software keeps both enables off while reconfiguring
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    ctrl_q <= `DMSP_CTRL_RST;
    baud_q <= `DMSP_BAUD_RST;
    mask_q <= `DMSP_MASK_RST;
  end
  else if (wr)
  begin
    if (is_reg(paddr, `DMSP_CTRL_OFS))
      ctrl_q <= pwdata[6:0];
    if (is_reg(paddr, `DMSP_BAUD_OFS))
      baud_q <= pwdata[7:0];
    if (is_reg(paddr, `DMSP_IRQMSK_OFS))
      mask_q <= pwdata[1:0];
  end
end
// ----------------------------------------------------------------
// interrupts
// ----------------------------------------------------------------
// selected source; the forced flags on enable raise it too
assign tx_irq_ev = tx_en && (ctrl_q[`DMSP_CTRL_TXI_SEL] ? tsc_q : tbe_q)
  && !(irqst_q[`DMSP_IRQ_TX]);
assign rx_irq_ev = rx_run && (rxcnt_q == (async_m ? 4'h9 : 4'h7))
  && sh_rise && (rxbusy_q || !async_m);
assign w1c = (wr && is_reg(paddr, `DMSP_IRQST_OFS)) ? pwdata[1:0]
                                                     : 2'h0;
// tx level source would re-set after clear; latch on rising source
reg txsrc_d1_q;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    irqst_q <= 2'h0;
    txsrc_d1_q <= 1'b0;
  end
  else
  begin
    txsrc_d1_q <= tx_en && (ctrl_q[`DMSP_CTRL_TXI_SEL] ? tsc_q : tbe_q);
    irqst_q[`DMSP_IRQ_TX] <= (tx_irq_ev && !txsrc_d1_q) ||
      (irqst_q[`DMSP_IRQ_TX] && !w1c[0]);
    irqst_q[`DMSP_IRQ_RX] <= rx_irq_ev ||
      (irqst_q[`DMSP_IRQ_RX] && !w1c[1]);
  end
end
assign irq = |(irqst_q & mask_q);
// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @*
begin
  prdata = 32'h00000000;
  case (paddr)
    `DMSP_CTRL_OFS: prdata = {25'h0000000, ctrl_q};
    `DMSP_TXBUF_OFS: prdata = {24'h000000, txbuf_q};
    `DMSP_RXBUF_OFS: prdata = {24'h000000, rxbuf_q};
    `DMSP_STAT_OFS: prdata = {29'h00000000, rbf_q, tsc_q, tbe_q};
    `DMSP_IRQST_OFS: prdata = {30'h00000000, irqst_q};
    `DMSP_IRQMSK_OFS: prdata = {30'h00000000, mask_q};
    `DMSP_BAUD_OFS: prdata = {24'h000000, baud_q};
    default: prdata = 32'h00000000;
  endcase
end
endmodule // dmsp_core

// ==== testbench/dmsp_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module dmsp_monitor
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire irq,
  input wire txd_in,
  input wire rxd_in,
  input wire txd_out,
  input wire txd_oe,
  input wire shift_clock_pin_out,
  input wire shift_clock_pin_oe,
  input wire receiver_ready_pin_oe,
  input wire [3:0] gpio_in_q
);
  reg wr_q;
  reg [2:0] up_q;
  // write strobe one edge late; up_q hides pre-reset history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q <= 1'b0;
      up_q <= 3'h0;
    end
    else
    begin
      wr_q <= psel & penable & pwrite;
      up_q <= (up_q == 3'h4) ? up_q : up_q + 3'h1;
    end
  end
  sequence wr_s;
    wr_q;
  endsequence
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rdy_needs_tx_a:
    assert property (receiver_ready_pin_oe |-> txd_oe)
    else $error("ready output without transmit");
  txd_oe_write_a:
    assert property ($changed(txd_oe) |-> wr_s)
    else $error("txd enable moved without write");
  sclk_oe_write_a:
    assert property ($changed(shift_clock_pin_oe) |-> wr_s)
    else $error("clock enable moved without write");
  rdy_oe_write_a:
    assert property ($changed(receiver_ready_pin_oe) |-> wr_s)
    else $error("ready enable moved without write");
  irq_fall_write_a:
    assert property ($fell(irq) |-> wr_s)
    else $error("irq fell without write");
  gpio_txd_a:
    assert property (up_q == 3'h4 |-> gpio_in_q[0] == $past(txd_in, 3))
    else $error("general port txd level wrong");
  gpio_rxd_a:
    assert property (up_q == 3'h4 |->
      gpio_in_q[1] == $past(rxd_in, 3) && !gpio_in_q[3])
    else $error("general port rxd level wrong");
  tx_clock_low_a:
    assert property ($changed(txd_out) && shift_clock_pin_oe &&
      $past(shift_clock_pin_oe) |-> !shift_clock_pin_out)
    else $error("data moved while clock high");
endmodule // dmsp_monitor

// ==== testbench/dmsp_partner.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side serial device
// ----------------------------------------------------------------
module dmsp_partner
(
  input wire sclk,
  input wire txd,
  output logic rxd,
  output logic ext_clk,
  output logic [7:0] got_q
);
  int bit_n = 0;
  // lines idle high, as with a pull-up
  initial
  begin
    rxd = 1'b1;
    ext_clk = 1'b1;
  end
  // drive on fall, sample on rise: one clock serves both ways
  always @(negedge sclk)
  begin
    rxd <= bit_n[0] ^ bit_n[2];
    bit_n <= (bit_n + 1) % 8;
  end
  always @(posedge sclk)
    got_q <= {txd, got_q[7:1]};
  // 400 ns clock only inside a frame, free phase
  task frame();
    #37;
    repeat (8)
    begin
      #200 ext_clk = 1'b0;
      #200 ext_clk = 1'b1;
    end
  endtask
endmodule // dmsp_partner

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "dmsp_map.vh"
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module testbench;
  // control bits and offsets
  localparam PE = 1, TE = 2, RE = 4, AS = 8, EX = 16, RY = 32, SL = 64;
  localparam C = `DMSP_CTRL_OFS, T = `DMSP_TXBUF_OFS, S = `DMSP_STAT_OFS;
  logic pclk, presetn, psel, penable, pwrite, tin;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, irq, txd_out, txd_oe, sclk_o, sclk_oe, rdy_n, rdy_oe;
  wire rxd, ext;
  wire [7:0] got;
  wire sclk = sclk_oe ? sclk_o : ext;
  int fail_count = 0;
  int check_count = 0;
  dmsp_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(), .irq, .txd_in(tin), .txd_out,
    .txd_oe, .rxd_in(rxd), .shift_clock_pin_in(ext),
    .shift_clock_pin_out(sclk_o), .shift_clock_pin_oe(sclk_oe),
    .receiver_ready_pin_n(rdy_n), .receiver_ready_pin_oe(rdy_oe),
    .gpio_in_q());
  dmsp_partner far_u (.sclk, .txd(txd_out), .rxd, .ext_clk(ext),
    .got_q(got));
  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string w, logic [31:0] e, logic [31:0] v);
    check_count++;
    if (v !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, e, v);
    end
  endtask
  // one apb transfer; #1 lets the write land before pins are looked at
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      if (++n > 50)
      begin
        fail_count++;
        final_report();
      end
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdc(string w, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask
  // bounded poll of one status bit
  task automatic wait_st(int b, logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, S, 32'h0);
      if (++n > 400)
      begin
        fail_count++;
        final_report();
      end
    end
    while (rd[b] !== v);
  endtask
  task t_reset();
    rdc("ctrl", C, 32'h0);
    rdc("baud", `DMSP_BAUD_OFS, `DMSP_BAUD_RST);
    rdc("unmapped", 12'h01C, 32'h0);
    chk("pins", 6'h24, {txd_out, txd_oe, sclk_oe, rdy_n, rdy_oe, irq});
    $display("reset test done");
  endtask
  task t_txen();
    apb(1'b1, `DMSP_IRQMSK_OFS, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, C, 32'h0);
      apb(1'b1, C, PE | TE | (s ? SL : 0));
      rdc("flags", S, 32'h3);
      rdc("tx req", `DMSP_IRQST_OFS, 32'h1);
      chk("irq", 1'h1, irq);
      apb(1'b1, `DMSP_IRQST_OFS, 32'h1);
      chk("irq clr", 1'h0, irq);
    end
    $display("enable test done");
  endtask
  task t_sync();
    apb(1'b1, T, 32'h5A);
    repeat (10) @(posedge pclk);
    apb(1'b0, S, 32'h0);
    chk("tsc", 1'h0, rd[1]);
    chk("oe", 2'h3, {txd_oe, sclk_oe});
    wait_st(1, 1'b1);
    chk("sent", 8'h5A, got);
    apb(1'b1, C, 32'h0);
    apb(1'b1, C, PE | RE | RY);
    chk("rdy off", 1'h0, rdy_oe);
    apb(1'b1, C, 32'h0);
    apb(1'b1, C, PE | TE | RE | RY);
    chk("rdy", 2'h2, {rdy_oe, rdy_n});
    apb(1'b1, T, 32'h0);
    wait_st(2, 1'b1);
    // partner pattern restarts after the eight falls of the first frame
    rdc("rx", `DMSP_RXBUF_OFS, 32'h5A);
    apb(1'b1, C, PE | TE);
    apb(1'b1, T, 32'hFF);
    wait_st(1, 1'b0);
    wait_st(1, 1'b1);
    rdc("rx off", S, 32'h3);
    $display("sync test done");
  endtask
  task t_async();
    apb(1'b1, C, 32'h0);
    apb(1'b1, C, PE | TE | RE | AS);
    apb(1'b1, T, 32'h96);
    wait_st(1, 1'b0);
    apb(1'b1, C, PE | TE | AS);
    apb(1'b0, S, 32'h0);
    chk("tx on", 2'h1, {rd[1], txd_oe});
    wait_st(1, 1'b1);
    apb(1'b1, C, PE | AS);
    chk("tx off", 1'h0, txd_oe);
    $display("async test done");
  endtask
  task t_off();
    apb(1'b1, C, 32'h0);
    apb(1'b1, C, TE);
    apb(1'b1, T, 32'h3C);
    tin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, S, 32'h0);
    chk("shifting", 1'h0, rd[1]);
    chk("pins off", 3'h0, {txd_oe, sclk_oe, rdy_oe});
    apb(1'b1, C, PE | TE);
    chk("driven", 1'h1, txd_oe);
    wait_st(1, 1'b1);
    $display("disabled test done");
  endtask
  task t_ext();
    apb(1'b1, C, 32'h0);
    apb(1'b1, C, PE | TE | EX);
    chk("clk in", 1'h0, sclk_oe);
    apb(1'b1, T, 32'h69);
    far_u.frame();
    repeat (8) @(posedge pclk);
    chk("ext sent", 8'h69, got);
    $display("external clock test done");
  endtask
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    tin = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_txen();
    t_sync();
    t_async();
    t_off();
    t_ext();
    final_report();
  end
endmodule // testbench
bind dmsp_core dmsp_monitor mon_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .irq, .txd_in, .rxd_in, .txd_out, .txd_oe,
  .shift_clock_pin_out, .shift_clock_pin_oe, .receiver_ready_pin_oe,
  .gpio_in_q);
